// *** inc/csr_regs.svh ***
/*
  Register indices, status bits and reset values.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef CSR_REGS_SVH
`define CSR_REGS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address on APB is four times the index)
// ----------------------------------------------------------------------
`define CSR_IDX_PORT0     8'h00
`define CSR_IDX_PTR0      8'h01
`define CSR_IDX_PORT1     8'h02
`define CSR_IDX_PTR1_LOW  8'h03
`define CSR_IDX_PTR1_SEC  8'h04
`define CSR_IDX_ACC       8'h05
`define CSR_IDX_PC_LOW 8'h06
`define CSR_IDX_TBL_LOW   8'h07
`define CSR_IDX_TBL_DATA  8'h08
`define CSR_IDX_TBL_HIGH  8'h09
`define CSR_IDX_STATUS    8'h0A
`define CSR_IDX_PORT2     8'h0C
`define CSR_IDX_PTR2_LOW  8'h0D
`define CSR_IDX_PTR2_SEC  8'h0E
`define CSR_IDX_EXT_ADDR  8'h10
`define CSR_IDX_EXT_DATA  8'h11

// Index field of the APB byte address
`define CSR_IDX_MSB 6
`define CSR_IDX_LSB 2

// ----------------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------------
`define CSR_ST_C   0
`define CSR_ST_NIB 1
`define CSR_ST_Z 2
`define CSR_ST_SW 3
`define CSR_ST_SLP 4
`define CSR_ST_EXP 5
`define CSR_ST_CN 6
`define CSR_ST_SX 7

// Bits that software may write in the status register
`define CSR_ST_WR_MASK 8'hCF
`define CSR_ST_RESET   8'h00
`define CSR_BYTE_RESET 8'h00
`define CSR_SECTOR0    4'h0

`endif

// *** inc/csr_pkg.sv ***
/*
  ALU operations and APB slave states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package csr_pkg;

  // Operations the execution unit hands to the ALU
  typedef enum logic [3:0] {
    CSR_OP_ADD,
    CSR_OP_ADC,
    CSR_OP_SUB,
    CSR_OP_SUBB,
    CSR_OP_AND,
    CSR_OP_OR,
    CSR_OP_XOR,
    CSR_OP_RLC,
    CSR_OP_RRC
  } csr_op_t;

  // APB slave phases
  typedef enum logic [1:0] {
    CSR_ST_IDLE,
    CSR_ST_MEM,
    CSR_ST_DONE
  } csr_bus_t;

endpackage

// *** logic/csr_core.sv ***
/*
  Core special registers behind an APB slave: pointers, ALU, status.
  Assumes all neighbours run on clk_i and events are one-cycle pulses.
*/
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
// How it works
// RULE1: Port aimed at itself reads zero, ignores writes.
// RULE2: Port 0 reaches only sector 0 at pointer 0.
// RULE3: Ports 1 and 2 take offset and sector from pointers.
// RULE4: Five pointer bytes are plain storage.
// RULE5: Extended address splits into sector and offset.
// RULE6: Counter low write jumps within the page.
// RULE7: One idle cycle follows that jump.
// RULE8: Table read fetches at the two table pointers.
// RULE9: High byte to table data, low byte to destination.
// RULE10: Every ALU result lands in the accumulator.
// RULE11: Status writes keep expiry and sleep flags.
// RULE12: Expiry cleared by reset, refresh, sleep; set on timeout.
// RULE13: Sleep flag cleared by reset or refresh; set by sleep.
// RULE14: Carry on add carry or no borrow; rotates update it.
// RULE15: Nibble flag on low nibble carry or no borrow.
// RULE16: Zero flag when arithmetic or logic result is zero.
// RULE17: Overflow when carry into bit 7 differs from out.
// RULE18: Bit 7 is overflow xor result msb.
// RULE19: Chained flag copies zero on subtract, ands on borrow.
// RULE20: Status never saved automatically.
// RULE21: Untouched flags keep their value.
`timescale 1ns/100ps
`include "csr_regs.svh"

module csr_core
  import csr_pkg::*;
#(
  parameter int SECT_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  // Data memory
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [SECT_W-1:0] mem_sector_o,
  output logic [7:0] mem_offset_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  input wire logic mem_ack_i,
  // ALU requests
  input wire logic alu_valid_i,
  input wire csr_op_t alu_op_i,
  input wire logic [7:0] alu_b_i,
  // Program counter low byte
  output logic pc_load_o,
  output logic [7:0] pc_low_o,
  output logic dummy_cycle_o,
  // Table read
  input wire logic tbl_rd_i,
  output logic prog_req_o,
  output logic [15:0] prog_addr_o,
  input wire logic [15:0] prog_data_i,
  input wire logic prog_ack_i,
  output logic tbl_done_o,
  output logic [7:0] tbl_low_o,
  // System events
  input wire logic wdt_timeout_i,
  input wire logic dog_refresh_instr_i,
  input wire logic halt_i,
  output logic [7:0] status_o,
  output logic [7:0] acc_o
);

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  logic [7:0] ptr0_q, ptr1_low_q, ptr2_low_q;
  logic [7:0] ptr1_sec_q, ptr2_sec_q;
  logic [SECT_W+7:0] ext_addr_q;
  logic [7:0] acc_q, pc_low_q, tbl_low_q, tbl_high_q, tbl_data_q;
  logic [7:0] status_q, status_d;
  logic pc_load_q, dummy_q, prog_req_q, tbl_done_q;
  logic [7:0] tbl_out_q;
  csr_bus_t bus_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic mem_req_q, mem_we_q;
  logic [SECT_W-1:0] mem_sector_q;
  logic [7:0] mem_offset_q, mem_wdata_q;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  wire [7:0] idx = {3'b000, paddr_i[`CSR_IDX_MSB:`CSR_IDX_LSB]};
  wire access = psel_i && penable_i && !pready_q;
  wire hit_p0 = idx == `CSR_IDX_PORT0;
  wire hit_p1 = idx == `CSR_IDX_PORT1;
  wire hit_p2 = idx == `CSR_IDX_PORT2;
  wire hit_ext = idx == `CSR_IDX_EXT_DATA;
  wire hit_port = hit_p0 || hit_p1 || hit_p2 || hit_ext;
  wire hit_reg = idx == `CSR_IDX_PTR0 || idx == `CSR_IDX_PTR1_LOW ||
                 idx == `CSR_IDX_PTR1_SEC || idx == `CSR_IDX_ACC ||
                 idx == `CSR_IDX_PC_LOW || idx == `CSR_IDX_TBL_LOW ||
                 idx == `CSR_IDX_TBL_DATA || idx == `CSR_IDX_TBL_HIGH ||
                 idx == `CSR_IDX_STATUS || idx == `CSR_IDX_PTR2_LOW ||
                 idx == `CSR_IDX_PTR2_SEC || idx == `CSR_IDX_EXT_ADDR;
  wire upper_zero = paddr_i[31:`CSR_IDX_MSB+1] == '0;
  wire mapped = upper_zero && (hit_port || hit_reg);
  wire wr_en = access && bus_q == CSR_ST_IDLE && pwrite_i && mapped;

  // --------------------------------------------------------------------
  // Indirect target selection
  // --------------------------------------------------------------------
  // RULE2: port zero sector
  wire [SECT_W-1:0] p0_sec = `CSR_SECTOR0;
  // RULE3: sector from pointer
  wire [SECT_W-1:0] p1_sec = ptr1_sec_q[SECT_W-1:0];
  wire [SECT_W-1:0] p2_sec = ptr2_sec_q[SECT_W-1:0];
  // RULE5: extended address split
  wire [SECT_W-1:0] ext_sec = ext_addr_q[SECT_W+7:8];
  wire [SECT_W-1:0] tgt_sec = hit_p0 ? p0_sec : hit_p1 ? p1_sec :
                              hit_p2 ? p2_sec : ext_sec;
  wire [7:0] tgt_off = hit_p0 ? ptr0_q : hit_p1 ? ptr1_low_q :
                       hit_p2 ? ptr2_low_q : ext_addr_q[7:0];
  // RULE1: port aimed at a port
  wire tgt_self = tgt_sec == `CSR_SECTOR0 &&
                  (tgt_off == `CSR_IDX_PORT0 || tgt_off == `CSR_IDX_PORT1 ||
                   tgt_off == `CSR_IDX_PORT2 ||
                   tgt_off == `CSR_IDX_EXT_DATA);
  wire go_mem = upper_zero && hit_port && !tgt_self;

  // Register read mux
  logic [7:0] reg_rd;
  always_comb begin
    unique case (idx)
      `CSR_IDX_PTR0: reg_rd = ptr0_q;
      `CSR_IDX_PTR1_LOW: reg_rd = ptr1_low_q;
      `CSR_IDX_PTR1_SEC: reg_rd = ptr1_sec_q;
      `CSR_IDX_ACC: reg_rd = acc_q;
      `CSR_IDX_PC_LOW: reg_rd = pc_low_q;
      `CSR_IDX_TBL_LOW: reg_rd = tbl_low_q;
      `CSR_IDX_TBL_DATA: reg_rd = tbl_data_q;
      `CSR_IDX_TBL_HIGH: reg_rd = tbl_high_q;
      `CSR_IDX_STATUS: reg_rd = status_q;
      `CSR_IDX_PTR2_LOW: reg_rd = ptr2_low_q;
      `CSR_IDX_PTR2_SEC: reg_rd = ptr2_sec_q;
      `CSR_IDX_EXT_ADDR: reg_rd = ext_addr_q[7:0];
      default: reg_rd = `CSR_BYTE_RESET;
    endcase
  end
  // Extended address is wider than a byte; its sector sits above bit 7
  wire [31:0] rd_word = idx == `CSR_IDX_EXT_ADDR ?
                        32'(ext_addr_q) : {24'h00_0000, reg_rd};

  // --------------------------------------------------------------------
  // APB slave: one wait state for registers, memory paced by mem_ack_i
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_q <= CSR_ST_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_sector_q <= '0;
      mem_offset_q <= `CSR_BYTE_RESET;
      mem_wdata_q <= `CSR_BYTE_RESET;
    end else begin
      unique case (bus_q)
        CSR_ST_IDLE: begin
          pready_q <= 1'b0;
          if (access && go_mem) begin
            bus_q <= CSR_ST_MEM;
            mem_req_q <= 1'b1;
            mem_we_q <= pwrite_i;
            mem_sector_q <= tgt_sec;
            mem_offset_q <= tgt_off;
            mem_wdata_q <= pwdata_i[7:0];
          end else if (access) begin
            bus_q <= CSR_ST_DONE;
            pready_q <= 1'b1;
            pslverr_q <= !mapped;
            // RULE1: self target reads zero
            prdata_q <= (pwrite_i || !mapped || hit_port) ?
                        32'h0000_0000 : rd_word;
          end
        end
        CSR_ST_MEM: begin
          if (mem_ack_i) begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            pready_q <= 1'b1;
            pslverr_q <= 1'b0;
            prdata_q <= mem_we_q ? 32'h0000_0000 :
                        {24'h00_0000, mem_rdata_i};
            bus_q <= CSR_ST_DONE;
          end
        end
        CSR_ST_DONE: begin
          pready_q <= 1'b0;
          pslverr_q <= 1'b0;
          bus_q <= CSR_ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // ALU: result and flags computed from the accumulator and operand
  // --------------------------------------------------------------------
  wire is_sub = alu_op_i == CSR_OP_SUB || alu_op_i == CSR_OP_SUBB;
  wire is_arith = is_sub || alu_op_i == CSR_OP_ADD ||
                  alu_op_i == CSR_OP_ADC;
  wire is_logic = alu_op_i == CSR_OP_AND || alu_op_i == CSR_OP_OR ||
                  alu_op_i == CSR_OP_XOR;
  wire is_rot = alu_op_i == CSR_OP_RLC || alu_op_i == CSR_OP_RRC;
  // Subtract is add of the complement; carry in is the no-borrow bit
  wire [7:0] b_eff = is_sub ? ~alu_b_i : alu_b_i;
  wire cin = alu_op_i == CSR_OP_SUB ? 1'b1 :
             (alu_op_i == CSR_OP_ADC || alu_op_i == CSR_OP_SUBB) ?
             status_q[`CSR_ST_C] : 1'b0;
  wire [8:0] sum9 = 9'({1'b0, acc_q} + {1'b0, b_eff} + {8'h00, cin});
  wire [4:0] low5 = 5'({1'b0, acc_q[3:0]} + {1'b0, b_eff[3:0]} +
                       {4'h0, cin});
  wire [7:0] low8 = 8'({1'b0, acc_q[6:0]} + {1'b0, b_eff[6:0]} +
                       {7'h00, cin});
  logic [7:0] alu_res;
  always_comb begin
    unique case (alu_op_i)
      CSR_OP_AND: alu_res = acc_q & alu_b_i;
      CSR_OP_OR: alu_res = acc_q | alu_b_i;
      CSR_OP_XOR: alu_res = acc_q ^ alu_b_i;
      CSR_OP_RLC: alu_res = {acc_q[6:0], status_q[`CSR_ST_C]};
      CSR_OP_RRC: alu_res = {status_q[`CSR_ST_C], acc_q[7:1]};
      default: alu_res = sum9[7:0];
    endcase
  end
  wire res_zero = alu_res == 8'h00;
  wire ov_new = low8[7] ^ sum9[8];

  // Next status value: bus write, then ALU, then system events
  always_comb begin
    status_d = status_q;
    // RULE11: expiry and sleep flags masked
    if (wr_en && idx == `CSR_IDX_STATUS) begin
      status_d = (status_q & ~`CSR_ST_WR_MASK) |
                 (pwdata_i[7:0] & `CSR_ST_WR_MASK);
    end
    // RULE21: untouched flags hold
    if (alu_valid_i && is_arith) begin
      // RULE14: carry or no borrow
      status_d[`CSR_ST_C] = sum9[8];
      // RULE15: nibble carry
      status_d[`CSR_ST_NIB] = low5[4];
      // RULE17: carry in versus out
      status_d[`CSR_ST_SW] = ov_new;
      // RULE18: overflow xor msb
      status_d[`CSR_ST_SX] = ov_new ^ alu_res[7];
      // RULE19: chained zero flag
      if (alu_op_i == CSR_OP_SUB) begin
        status_d[`CSR_ST_CN] = res_zero;
      end else if (alu_op_i == CSR_OP_SUBB) begin
        status_d[`CSR_ST_CN] = status_q[`CSR_ST_CN] & res_zero;
      end
    end
    // RULE16: zero on arith and logic
    if (alu_valid_i && (is_arith || is_logic)) begin
      status_d[`CSR_ST_Z] = res_zero;
    end
    // RULE14: rotate through carry
    if (alu_valid_i && is_rot) begin
      status_d[`CSR_ST_C] = alu_op_i == CSR_OP_RLC ? acc_q[7] : acc_q[0];
    end
    // RULE12: expiry flag, timeout wins
    if (dog_refresh_instr_i || halt_i) begin
      status_d[`CSR_ST_EXP] = 1'b0;
    end
    if (wdt_timeout_i) begin
      status_d[`CSR_ST_EXP] = 1'b1;
    end
    // RULE13: sleep flag, sleep wins
    if (dog_refresh_instr_i) begin
      status_d[`CSR_ST_SLP] = 1'b0;
    end
    if (halt_i) begin
      status_d[`CSR_ST_SLP] = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Register storage; ALU result beats a bus write to the accumulator
  // --------------------------------------------------------------------
  // RULE20: status never pushed on call
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= `CSR_ST_RESET;
      acc_q <= `CSR_BYTE_RESET;
    end else begin
      status_q <= status_d;
      // RULE10: result into accumulator
      if (alu_valid_i) begin
        acc_q <= alu_res;
      end else if (wr_en && idx == `CSR_IDX_ACC) begin
        acc_q <= pwdata_i[7:0];
      end
    end
  end

  // RULE4: pointer bytes are storage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr0_q <= `CSR_BYTE_RESET;
      ptr1_low_q <= `CSR_BYTE_RESET;
      ptr1_sec_q <= `CSR_BYTE_RESET;
      ptr2_low_q <= `CSR_BYTE_RESET;
      ptr2_sec_q <= `CSR_BYTE_RESET;
      ext_addr_q <= '0;
      tbl_low_q <= `CSR_BYTE_RESET;
      tbl_high_q <= `CSR_BYTE_RESET;
    end else if (wr_en) begin
      if (idx == `CSR_IDX_PTR0) ptr0_q <= pwdata_i[7:0];
      if (idx == `CSR_IDX_PTR1_LOW) ptr1_low_q <= pwdata_i[7:0];
      if (idx == `CSR_IDX_PTR1_SEC) ptr1_sec_q <= pwdata_i[7:0];
      if (idx == `CSR_IDX_PTR2_LOW) ptr2_low_q <= pwdata_i[7:0];
      if (idx == `CSR_IDX_PTR2_SEC) ptr2_sec_q <= pwdata_i[7:0];
      if (idx == `CSR_IDX_EXT_ADDR) ext_addr_q <= pwdata_i[SECT_W+7:0];
      if (idx == `CSR_IDX_TBL_LOW) tbl_low_q <= pwdata_i[7:0];
      if (idx == `CSR_IDX_TBL_HIGH) tbl_high_q <= pwdata_i[7:0];
    end
  end

  // RULE6: low byte jump request
  // RULE7: idle cycle follows the jump
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_low_q <= `CSR_BYTE_RESET;
      pc_load_q <= 1'b0;
      dummy_q <= 1'b0;
    end else begin
      pc_load_q <= wr_en && idx == `CSR_IDX_PC_LOW;
      dummy_q <= pc_load_q;
      if (wr_en && idx == `CSR_IDX_PC_LOW) pc_low_q <= pwdata_i[7:0];
    end
  end

  // RULE8: fetch at table pointers
  // RULE9: split fetched word
  // A new table read is ignored while one is still in flight.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prog_req_q <= 1'b0;
      tbl_done_q <= 1'b0;
      tbl_out_q <= `CSR_BYTE_RESET;
      tbl_data_q <= `CSR_BYTE_RESET;
    end else begin
      tbl_done_q <= 1'b0;
      if (prog_req_q && prog_ack_i) begin
        prog_req_q <= 1'b0;
        tbl_done_q <= 1'b1;
        tbl_data_q <= prog_data_i[15:8];
        tbl_out_q <= prog_data_i[7:0];
      end else if (tbl_rd_i) begin
        prog_req_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // --------------------------------------------------------------------
  assign pready_o = pready_q;
  assign prdata_o = prdata_q;
  assign pslverr_o = pslverr_q;
  assign mem_req_o = mem_req_q;
  assign mem_we_o = mem_we_q;
  assign mem_sector_o = mem_sector_q;
  assign mem_offset_o = mem_offset_q;
  assign mem_wdata_o = mem_wdata_q;
  assign pc_load_o = pc_load_q;
  assign pc_low_o = pc_low_q;
  assign dummy_cycle_o = dummy_q;
  assign prog_req_o = prog_req_q;
  assign prog_addr_o = {tbl_high_q, tbl_low_q};
  assign tbl_done_o = tbl_done_q;
  assign tbl_low_o = tbl_out_q;
  assign status_o = status_q;
  assign acc_o = acc_q;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_port_self_zero: assert property ( // RULE1
    @(posedge clk_i) disable iff (rst_i)
    access && bus_q == CSR_ST_IDLE && upper_zero && hit_port && tgt_self
    |=> pready_o && prdata_o == 32'h0000_0000 && !mem_req_o)
    else $error("self aimed port not zero");

  a_port0_sector: assert property ( // RULE2
    @(posedge clk_i) disable iff (rst_i)
    access && bus_q == CSR_ST_IDLE && go_mem && hit_p0
    |=> mem_req_o && mem_sector_o == '0 && mem_offset_o == $past(ptr0_q))
    else $error("port 0 left sector 0");

  a_port1_target: assert property ( // RULE3
    @(posedge clk_i) disable iff (rst_i)
    access && bus_q == CSR_ST_IDLE && go_mem && hit_p1
    |=> mem_sector_o == $past(p1_sec) && mem_offset_o == $past(ptr1_low_q))
    else $error("port 1 target wrong");

  a_jump_idle: assert property ( // RULE7
    @(posedge clk_i) disable iff (rst_i)
    wr_en && idx == `CSR_IDX_PC_LOW
    |=> pc_load_o && !dummy_cycle_o ##1 dummy_cycle_o && !pc_load_o)
    else $error("idle cycle missing after jump");

  a_acc_result: assert property ( // RULE10
    @(posedge clk_i) disable iff (rst_i)
    alu_valid_i |=> acc_o == $past(alu_res))
    else $error("result not in accumulator");

  a_status_keep: assert property ( // RULE11
    @(posedge clk_i) disable iff (rst_i)
    wr_en && idx == `CSR_IDX_STATUS && !wdt_timeout_i && !dog_refresh_instr_i &&
    !halt_i |=> $stable(status_o[5:4]))
    else $error("status write hit system flags");

  a_expiry_set: assert property ( // RULE12
    @(posedge clk_i) disable iff (rst_i)
    wdt_timeout_i |=> status_o[`CSR_ST_EXP])
    else $error("timeout lost");

  a_sleep_set: assert property ( // RULE13
    @(posedge clk_i) disable iff (rst_i)
    halt_i |=> status_o[`CSR_ST_SLP] && !status_o[`CSR_ST_EXP] ||
    $past(wdt_timeout_i))
    else $error("sleep flags wrong");

  a_zero_flag: assert property ( // RULE16
    @(posedge clk_i) disable iff (rst_i)
    alu_valid_i && (is_arith || is_logic)
    |=> status_o[`CSR_ST_Z] == (acc_o == 8'h00))
    else $error("zero flag wrong");

  a_sign_xor: assert property ( // RULE18
    @(posedge clk_i) disable iff (rst_i)
    alu_valid_i && is_arith
    |=> status_o[`CSR_ST_SX] == (status_o[`CSR_ST_SW] ^ acc_o[7]))
    else $error("sign xor flag wrong");

  a_table_split: assert property ( // RULE9
    @(posedge clk_i) disable iff (rst_i)
    prog_req_o && prog_ack_i
    |=> tbl_done_o && tbl_low_o == $past(prog_data_i[7:0]) &&
    tbl_data_q == $past(prog_data_i[15:8]))
    else $error("table word split wrong");

endmodule // csr_core

// *** tb/csr_mem_model.sv ***
/*
  Data and program memory seen by the core special registers.
  Assumes one clock and requests held until acknowledged.
*/
`timescale 1ns/100ps
module csr_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [3:0] sec_i,
  input wire logic [7:0] off_i,
  input wire logic [7:0] wd_i,
  output logic [7:0] rd_o,
  output logic ack_o,
  input wire logic preq_i,
  input wire logic [15:0] paddr_i,
  output logic [15:0] pdata_o,
  output logic pack_o
);
  logic [7:0] mem [16][256];
  logic [1:0] wait_q;
  logic ready;
  logic [15:0] word;
  // Lines outside an answer show the inverse, never a stale value
  assign word = paddr_i ^ 16'hA55A;
  assign rd_o = ack_o ? mem[sec_i][off_i] : ~mem[sec_i][off_i];
  assign pdata_o = pack_o ? word : ~word;
  assign ready = wait_q == {slow_i, slow_i};
  // Answer after one cycle, or four when slow
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_q <= 2'h0;
      ack_o <= 1'b0;
      pack_o <= 1'b0;
    end else begin
      ack_o <= req_i && !ack_o && ready;
      pack_o <= preq_i && !pack_o && ready;
      wait_q <= (req_i || preq_i) && !(ack_o || pack_o) ?
                wait_q + 2'h1 : 2'h0;
      if (req_i && we_i && ack_o) mem[sec_i][off_i] <= wd_i;
    end
  end
endmodule // csr_mem_model

// *** tb/core_special_registers_bench.sv ***
/*
  Self-checking bench of the core special registers.
  Assumes the memory model answers requests; drives APB itself.
*/
`timescale 1ns/100ps
`include "csr_regs.svh"
module core_special_registers_bench import csr_pkg::*;;
  logic clk_i = 0, rst_i = 1, psel, pen, pwr, slow, alu_v, tbl_rd;
  logic wdt, clr, halt;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0] mem_rd, mem_off, mem_wd, alu_b, pc_low, tbl_low, status, acc;
  logic [7:0] v, w, o, ea, es, b;
  logic [3:0] mem_sec, s;
  logic [15:0] prog_addr, prog_data, x;
  logic pready, pslverr, mem_req, mem_we, mem_ack, pc_load, dummy, err, jmp;
  logic prog_req, prog_ack, tbl_done;
  csr_op_t alu_op, op;
  int mismatches = 0, check_count = 0, cyc = 0, seed = 71744;
  logic [7:0] pidx [5] = '{`CSR_IDX_PTR0, `CSR_IDX_PTR1_LOW, `CSR_IDX_PTR1_SEC,
    `CSR_IDX_PTR2_LOW, `CSR_IDX_PTR2_SEC};
  csr_op_t cop [3] = '{CSR_OP_ADD, CSR_OP_SUB, CSR_OP_SUBB};
  logic [7:0] cb [3] = '{8'h01, 8'h80, 8'hFF};
  logic [7:0] evx [3] = '{8'hEF, 8'hDF, 8'hFF};
  csr_core csr_core_i (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_sector_o(mem_sec),
    .mem_offset_o(mem_off), .mem_wdata_o(mem_wd), .mem_rdata_i(mem_rd),
    .mem_ack_i(mem_ack), .alu_valid_i(alu_v), .alu_op_i(alu_op),
    .alu_b_i(alu_b), .pc_load_o(pc_load), .pc_low_o(pc_low),
    .dummy_cycle_o(dummy), .tbl_rd_i(tbl_rd), .prog_req_o(prog_req),
    .prog_addr_o(prog_addr), .prog_data_i(prog_data), .prog_ack_i(prog_ack),
    .tbl_done_o(tbl_done), .tbl_low_o(tbl_low), .wdt_timeout_i(wdt),
    .dog_refresh_instr_i(clr), .halt_i(halt), .status_o(status), .acc_o(acc));
  csr_mem_model csr_mem_model_i (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .req_i(mem_req), .we_i(mem_we), .sec_i(mem_sec), .off_i(mem_off),
    .wd_i(mem_wd), .rd_o(mem_rd), .ack_o(mem_ack), .preq_i(prog_req),
    .paddr_i(prog_addr), .pdata_o(prog_data), .pack_o(prog_ack));
  // ---------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ---------------------------------------------------------------
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  function automatic logic [7:0] rnd();
    return 8'($random(seed));
  endfunction
  // Expected {acc, flags}; carry-in chains through C
  function automatic logic [15:0] alu(csr_op_t p, logic [7:0] a, q, f);
    logic [8:0] t;
    logic [7:0] m, r;
    logic [4:0] h;
    logic ci, c7;
    m = p inside {CSR_OP_SUB, CSR_OP_SUBB} ? ~q : q;
    ci = p == CSR_OP_SUB || (p inside {CSR_OP_ADC, CSR_OP_SUBB} && f[0]);
    t = {2'h0, a[6:0]} + {2'h0, m[6:0]} + 9'(ci);
    h = {1'h0, a[3:0]} + {1'h0, m[3:0]} + 5'(ci);
    c7 = t[7];
    t = {1'h0, a} + {1'h0, m} + 9'(ci);
    r = t[7:0];
    case (p)
      CSR_OP_AND: r = a & q;
      CSR_OP_OR: r = a | q;
      CSR_OP_XOR: r = a ^ q;
      CSR_OP_RLC: {f[0], r} = {a, f[0]};
      CSR_OP_RRC: {r, f[0]} = {f[0], a};
      default: begin
        f[0] = t[8];
        f[1] = h[4];
        f[3] = c7 ^ t[8];
        f[7] = f[3] ^ r[7];
      end
    endcase
    if (p < CSR_OP_RLC) f[2] = r == 8'h00;
    if (p == CSR_OP_SUB) f[6] = f[2];
    if (p == CSR_OP_SUBB) f[6] = f[6] & f[2];
    return {r, f};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] ix, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= {22'h0, ix, 2'h0};
    pwdata <= d;
    @(posedge clk_i) pen <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    err = pslverr;
    jmp = pc_load;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic pulse(input int k);
    @(posedge clk_i) {wdt, halt, clr} <= 3'b100 >> k;
    @(posedge clk_i) {wdt, halt, clr} <= 3'h0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {psel, pen, pwr, slow, alu_v, tbl_rd, wdt, clr, halt} = 9'h000;
    {paddr, pwdata} = '0;
    alu_op = CSR_OP_ADD;
    alu_b = 8'h00;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(0, `CSR_IDX_STATUS, 0);
    chk("status reset", 0, rd);
    apb(0, 8'h0B, 0);
    chk("unmapped", 1, err);
    apb(1, 8'h1F, 8'hFF);
    chk("unmapped", 1, err);
    foreach (pidx[i]) begin
      v = rnd() & (i == 2 || i == 4 ? 8'h0F : 8'hFF);
      apb(1, pidx[i], v);
      apb(0, pidx[i], 0);
      chk("pointer", v, rd);
    end
    $display("test reset and pointers done");
    // Indirect ports, prompt and then slow memory
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      v = rnd();
      w = ~v;
      o = {2'h1, v[5:0]};
      s = v[7:4] | 4'h1;
      apb(1, `CSR_IDX_PTR0, o);
      apb(1, `CSR_IDX_PORT0, v);
      chk("sector zero", v, csr_mem_model_i.mem[0][o]);
      apb(1, `CSR_IDX_PTR1_SEC, s);
      apb(1, `CSR_IDX_PTR1_LOW, o);
      apb(1, `CSR_IDX_PORT1, w);
      chk("any sector", w, csr_mem_model_i.mem[s][o]);
      apb(0, `CSR_IDX_PORT0, 0);
      chk("port zero", v, rd);
      apb(1, `CSR_IDX_EXT_ADDR, 12'h1F0);
      apb(1, `CSR_IDX_EXT_DATA, v);
      chk("extended", v, csr_mem_model_i.mem[1][8'hF0]);
      apb(1, `CSR_IDX_PTR2_SEC, 1);
      apb(1, `CSR_IDX_PTR2_LOW, 8'hF0);
      apb(0, `CSR_IDX_PORT2, 0);
      chk("port two", v, rd);
      apb(1, `CSR_IDX_PTR1_SEC, 0);
      apb(1, `CSR_IDX_PTR1_LOW, `CSR_IDX_PORT2);
      apb(1, `CSR_IDX_PORT1, 8'hFF);
      apb(0, `CSR_IDX_PORT1, 0);
      chk("self port", 0, rd);
    end
    $display("test indirect done");
    v = rnd();
    apb(1, `CSR_IDX_PC_LOW, v);
    chk("pc load", 1, jmp);
    chk("pc low", v, pc_low);
    #1 chk("idle cycle", 1, dummy);
    o = rnd();
    apb(1, `CSR_IDX_TBL_LOW, o);
    apb(1, `CSR_IDX_TBL_HIGH, v);
    @(posedge clk_i) tbl_rd <= 1'b1;
    @(posedge clk_i) tbl_rd <= 1'b0;
    for (int i = 0; i < 20 && tbl_done !== 1'b1; i++) @(posedge clk_i);
    x = {v, o} ^ 16'hA55A;
    chk("table low", x[7:0], tbl_low);
    apb(0, `CSR_IDX_TBL_DATA, 0);
    chk("table high", x[15:8], rd);
    $display("test jump and table done");
    // Status writes and system events
    apb(1, `CSR_IDX_STATUS, 8'hFF);
    apb(0, `CSR_IDX_STATUS, 0);
    chk("status write", 8'hCF, rd);
    for (int k = 0; k < 3; k++) begin
      pulse(k & 1);
      apb(0, `CSR_IDX_STATUS, 0);
      chk("event", evx[k], rd);
    end
    apb(1, `CSR_IDX_STATUS, 0);
    apb(0, `CSR_IDX_STATUS, 0);
    chk("flags kept", 8'h30, rd);
    pulse(2);
    @(posedge clk_i) chk("refresh", 8'h00, status);
    $display("test status done");
    ea = 8'h7F;
    es = rnd() & 8'hCF;
    apb(1, `CSR_IDX_ACC, ea);
    apb(1, `CSR_IDX_STATUS, es);
    for (int i = 0; i < 60; i++) begin
      op = i < 3 ? cop[i] : csr_op_t'(4'(rnd() % 9));
      b = i < 3 ? cb[i] : rnd();
      {ea, es} = alu(op, ea, b, es);
      @(posedge clk_i);
      alu_v <= 1'b1;
      alu_op <= op;
      alu_b <= b;
      @(posedge clk_i) alu_v <= 1'b0;
      @(posedge clk_i);
      chk("acc", ea, acc);
      chk("flags", es, status);
    end
    apb(0, `CSR_IDX_ACC, 0);
    chk("acc read", ea, rd);
    $display("test alu done");
    wrap_up();
  end
endmodule // core_special_registers_bench
